// file: dspt_pkg.sv
// Constants, field layouts and types for the dual-slope PWM timer
// Behaviour
// - Phase-correct TOP is 0x00FF/0x01FF/0x03FF (modes 1-3), capture (10), compare A (11).
// - Dual-slope counter runs zero up to TOP and back down, without pause.
// - Counter leaves TOP on the next timer cycle, reversing direction.
// - Non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - Output mode field two gives non-inverted PWM, three gives inverted PWM.
// - Waveform reaches the pin only when its direction bit selects output.
// - Register-defined TOP supports 0x0003 up to the full 16-bit maximum.
// - Phase-correct mode sets the overflow flag whenever the counter reaches zero.
// - Phase-correct loads compares at TOP; compare A or capture flag set then too.
// - With fixed TOP, compare writes store zeros above the selected resolution.
// - A channel's compare flag is set whenever the counter matches its compare.
// - TOP below a channel's compare value means that channel never matches.
// - Phase-correct: compare zero keeps output low, compare TOP keeps high; inverted opposite.
// - Compare A defining TOP (modes 9, 11) with field one toggles output A.
// - Frequency-correct mode takes TOP from capture (mode 8) or compare A (mode 9).
// - Frequency-correct loads compares at zero and sets overflow in that cycle.
// - Frequency-correct sets compare A or capture flag when counter reaches TOP.
// - Frequency-correct: compare zero holds low, compare TOP drives high; inverted opposite.
// - Capture register used as TOP takes effect at once, unbuffered.
// - Waveform mode is two low bits of control A and bits 4:3 of control B.
package dspt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL_A  = 8'h00;
    localparam logic [7:0] OFF_CTRL_B  = 8'h04;
    localparam logic [7:0] OFF_COUNT   = 8'h08;
    localparam logic [7:0] OFF_CMP_A   = 8'h0C;
    localparam logic [7:0] OFF_CMP_B   = 8'h10;
    localparam logic [7:0] OFF_CAPTURE = 8'h14;
    localparam logic [7:0] OFF_FLAGS   = 8'h18;
    localparam logic [7:0] OFF_PIN_DIR = 8'h1C;

    // Field positions
    localparam int MODE_A_HI   = 7;
    localparam int MODE_B_HI   = 5;
    localparam int WGM_LO_HI   = 1;
    localparam int WGM_HI_HI   = 4;
    localparam int CS_HI       = 2;
    localparam int FLAG_OVF    = 0;
    localparam int FLAG_CMP_A  = 1;
    localparam int FLAG_CMP_B  = 2;
    localparam int FLAG_CAP    = 3;

    // Reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;

    // Waveform modes handled here
    localparam logic [3:0] WGM_PC8   = 4'h1;
    localparam logic [3:0] WGM_PC9   = 4'h2;
    localparam logic [3:0] WGM_PC10  = 4'h3;
    localparam logic [3:0] WGM_PFC_C = 4'h8;
    localparam logic [3:0] WGM_PFC_A = 4'h9;
    localparam logic [3:0] WGM_PC_C  = 4'hA;
    localparam logic [3:0] WGM_PC_A  = 4'hB;

    // Fixed TOP values
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] TOP_FULL  = 16'hFFFF;
    localparam logic [15:0] BOTTOM    = 16'h0000;

    // Output mode field encodings
    localparam logic [1:0] OM_OFF    = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_NONINV = 2'h2;
    localparam logic [1:0] OM_INV    = 2'h3;

    // Prescaler: clock select codes and divider masks
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] PRE_M8     = 10'h007;
    localparam logic [9:0] PRE_M64    = 10'h03F;
    localparam logic [9:0] PRE_M256   = 10'h0FF;
    localparam logic [9:0] PRE_M1024  = 10'h3FF;

    // Pin drive carrier
    typedef struct packed {
        logic level;
        logic oe;
    } dspt_pin_t;

endpackage : dspt_pkg

// file: dspt_timer.sv
// Dual-slope PWM timer with APB register access
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module dspt_timer (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Compare output pins
    output dspt_pkg::dspt_pin_t    pin_a,
    output dspt_pkg::dspt_pin_t    pin_b
);

    // Active TOP for the selected mode
    function automatic logic [15:0] top_sel(input logic [3:0] m, input logic [15:0] cap,
                                            input logic [15:0] cmpa);
        unique case (m)
            dspt_pkg::WGM_PC8:                     top_sel = dspt_pkg::TOP_8BIT;
            dspt_pkg::WGM_PC9:                     top_sel = dspt_pkg::TOP_9BIT;
            dspt_pkg::WGM_PC10:                    top_sel = dspt_pkg::TOP_10BIT;
            dspt_pkg::WGM_PC_C, dspt_pkg::WGM_PFC_C: top_sel = cap;
            dspt_pkg::WGM_PC_A, dspt_pkg::WGM_PFC_A: top_sel = cmpa;
            default:                               top_sel = dspt_pkg::TOP_FULL;
        endcase
    endfunction : top_sel

    // Resolution mask for compare writes
    function automatic logic [15:0] res_mask(input logic [3:0] m);
        unique case (m)
            dspt_pkg::WGM_PC8:  res_mask = dspt_pkg::TOP_8BIT;
            dspt_pkg::WGM_PC9:  res_mask = dspt_pkg::TOP_9BIT;
            dspt_pkg::WGM_PC10: res_mask = dspt_pkg::TOP_10BIT;
            default:            res_mask = dspt_pkg::TOP_FULL;
        endcase
    endfunction : res_mask

    // Registers
    logic [7:0]  ctrl_a_reg;
    logic [7:0]  ctrl_b_reg;
    logic [15:0] count_reg;
    logic        dir_up_reg;
    logic [15:0] capture_reg;
    logic [3:0]  flags_reg;
    logic [1:0]  pin_dir_reg;
    logic [9:0]  pre_reg;
    logic [15:0] buf_reg [2];
    logic [15:0] cmp_reg [2];
    logic [1:0]  chan_out_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    // Mode decode
    wire [3:0]  waveform_mode = {ctrl_b_reg[dspt_pkg::WGM_HI_HI -: 2],
                                 ctrl_a_reg[dspt_pkg::WGM_LO_HI -: 2]};
    wire        pc_mode  = (waveform_mode == dspt_pkg::WGM_PC8) || (waveform_mode == dspt_pkg::WGM_PC9)
                        || (waveform_mode == dspt_pkg::WGM_PC10) || (waveform_mode == dspt_pkg::WGM_PC_C)
                        || (waveform_mode == dspt_pkg::WGM_PC_A);
    wire        pfc_mode = (waveform_mode == dspt_pkg::WGM_PFC_C) || (waveform_mode == dspt_pkg::WGM_PFC_A);
    wire        dual     = pc_mode | pfc_mode;
    wire        top_is_a = (waveform_mode == dspt_pkg::WGM_PC_A) || (waveform_mode == dspt_pkg::WGM_PFC_A);
    wire        top_is_c = (waveform_mode == dspt_pkg::WGM_PC_C) || (waveform_mode == dspt_pkg::WGM_PFC_C);
    wire [15:0] top      = top_sel(waveform_mode, capture_reg, cmp_reg[0]);
    wire [15:0] wmask    = res_mask(waveform_mode);

    // Prescaler timer enable
    wire [2:0] cs   = ctrl_b_reg[dspt_pkg::CS_HI -: 3];
    wire       tick = (cs == dspt_pkg::CS_DIV1)
                   || ((cs == dspt_pkg::CS_DIV8)    && ((pre_reg & dspt_pkg::PRE_M8)    == dspt_pkg::PRE_M8))
                   || ((cs == dspt_pkg::CS_DIV64)   && ((pre_reg & dspt_pkg::PRE_M64)   == dspt_pkg::PRE_M64))
                   || ((cs == dspt_pkg::CS_DIV256)  && ((pre_reg & dspt_pkg::PRE_M256)  == dspt_pkg::PRE_M256))
                   || ((cs == dspt_pkg::CS_DIV1024) && ((pre_reg & dspt_pkg::PRE_M1024) == dspt_pkg::PRE_M1024));
    wire       step = tick & dual;

    // Counter position
    wire at_top = (count_reg == top);
    wire at_bot = (count_reg == dspt_pkg::BOTTOM);
    wire update = step & ((pc_mode & at_top & dir_up_reg) | (pfc_mode & at_bot));

    // APB decode; every access completes in one access cycle
    wire apb_wr     = psel & penable & pwrite;
    wire apb_setup  = psel & ~penable;
    wire wr_ctrl_a  = apb_wr && (paddr == dspt_pkg::OFF_CTRL_A);
    wire wr_ctrl_b  = apb_wr && (paddr == dspt_pkg::OFF_CTRL_B);
    wire wr_count   = apb_wr && (paddr == dspt_pkg::OFF_COUNT);
    wire wr_capture = apb_wr && (paddr == dspt_pkg::OFF_CAPTURE);
    wire wr_flags   = apb_wr && (paddr == dspt_pkg::OFF_FLAGS);
    wire wr_pin_dir = apb_wr && (paddr == dspt_pkg::OFF_PIN_DIR);
    wire [1:0] wr_cmp = {apb_wr && (paddr == dspt_pkg::OFF_CMP_B),
                         apb_wr && (paddr == dspt_pkg::OFF_CMP_A)};
    wire [1:0] match;

    // Read data selection
    logic [31:0] rd_mux;
    logic        rd_err;
    always_comb begin
        rd_err = 1'b0;
        unique case (paddr)
            dspt_pkg::OFF_CTRL_A:  rd_mux = {24'h000000, ctrl_a_reg};
            dspt_pkg::OFF_CTRL_B:  rd_mux = {24'h000000, ctrl_b_reg};
            dspt_pkg::OFF_COUNT:   rd_mux = {16'h0000, count_reg};
            dspt_pkg::OFF_CMP_A:   rd_mux = {16'h0000, buf_reg[0]};
            dspt_pkg::OFF_CMP_B:   rd_mux = {16'h0000, buf_reg[1]};
            dspt_pkg::OFF_CAPTURE: rd_mux = {16'h0000, capture_reg};
            dspt_pkg::OFF_FLAGS:   rd_mux = {28'h0000000, flags_reg};
            dspt_pkg::OFF_PIN_DIR: rd_mux = {30'h00000000, pin_dir_reg};
            default: begin
                rd_mux = 32'h00000000;
                rd_err = 1'b1;
            end
        endcase
    end

    // APB answer captured in setup, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (apb_setup) begin
            prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_reg <= rd_err;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pready  = 1'b1;

    // Control registers and free-running prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_reg  <= dspt_pkg::CTRL_RESET;
            ctrl_b_reg  <= dspt_pkg::CTRL_RESET;
            capture_reg <= dspt_pkg::VALUE_RESET;
            pin_dir_reg <= 2'h0;
            pre_reg     <= 10'h000;
        end else begin
            pre_reg <= pre_reg + 10'h001;
            if (wr_ctrl_a)
                ctrl_a_reg <= pwdata[7:0];
            if (wr_ctrl_b)
                ctrl_b_reg <= pwdata[7:0];
            if (wr_capture)
                capture_reg <= pwdata[15:0];
            if (wr_pin_dir)
                pin_dir_reg <= pwdata[1:0];
        end
    end

    // Up/down counter; a software write to the count wins over a step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg  <= dspt_pkg::VALUE_RESET;
            dir_up_reg <= 1'b1;
        end else if (wr_count) begin
            count_reg <= pwdata[15:0];
        end else if (step) begin
            if (dir_up_reg && at_top && !at_bot) begin
                count_reg  <= count_reg - 16'h0001;
                dir_up_reg <= 1'b0;
            end else if (dir_up_reg) begin
                count_reg <= count_reg + 16'h0001;
            end else if (at_bot) begin
                count_reg  <= count_reg + 16'h0001;
                dir_up_reg <= 1'b1;
            end else begin
                count_reg <= count_reg - 16'h0001;
            end
        end
    end

    // Event flags: hardware set wins over write-one-to-clear
    wire [3:0] flag_set;
    assign flag_set[dspt_pkg::FLAG_OVF]   = step & at_bot;
    assign flag_set[dspt_pkg::FLAG_CMP_A] = match[0];
    assign flag_set[dspt_pkg::FLAG_CMP_B] = match[1];
    assign flag_set[dspt_pkg::FLAG_CAP]   = step & at_top & top_is_c;
    wire [3:0] flag_clr = wr_flags ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flags_reg <= dspt_pkg::FLAGS_RESET;
        else
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end

    // Per-channel compare buffer, match and waveform
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chan
            wire [1:0]  field = ctrl_a_reg[dspt_pkg::MODE_A_HI - 2 * i -: 2];
            wire [15:0] wval  = pwdata[15:0] & wmask;
            // Match only on exact equality, so a compare above TOP never fires
            assign match[i] = step && (count_reg == cmp_reg[i]);
            // Extremes pin the level; otherwise clear going up, set going down
            wire nonin = (cmp_reg[i] == dspt_pkg::BOTTOM) ? 1'b0 :
                         (cmp_reg[i] == top)             ? 1'b1 : ~dir_up_reg;
            wire tog_ok = (i == 0) && top_is_a;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_reg[i] <= dspt_pkg::VALUE_RESET;
                    cmp_reg[i] <= dspt_pkg::VALUE_RESET;
                end else begin
                    if (wr_cmp[i])
                        buf_reg[i] <= wval;
                    // Outside the dual-slope modes the buffer is transparent
                    if (wr_cmp[i] && !dual)
                        cmp_reg[i] <= wval;
                    else if (update)
                        cmp_reg[i] <= buf_reg[i];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    chan_out_reg[i] <= 1'b0;
                end else if (match[i]) begin
                    if (field == dspt_pkg::OM_NONINV)
                        chan_out_reg[i] <= nonin;
                    else if (field == dspt_pkg::OM_INV)
                        chan_out_reg[i] <= ~nonin;
                    else if (field == dspt_pkg::OM_TOGGLE && tog_ok)
                        chan_out_reg[i] <= ~chan_out_reg[i];
                end
            end
        end
    endgenerate

    // Pin drive; enable needs direction bit and a connected field
    assign pin_a.level = chan_out_reg[0];
    assign pin_a.oe    = pin_dir_reg[0] && (g_chan[0].field != dspt_pkg::OM_OFF);
    assign pin_b.level = chan_out_reg[1];
    assign pin_b.oe    = pin_dir_reg[1] && (g_chan[1].field != dspt_pkg::OM_OFF);

endmodule : dspt_timer

// file: dspt_load.sv
// Load model on the two compare pins
`timescale 1ns/1ps
module dspt_load (
    // Pins from the timer
    input  dspt_pkg::dspt_pin_t pin_a,
    input  dspt_pkg::dspt_pin_t pin_b,
    // Levels seen by the load
    output logic                wire_a,
    output logic                wire_b
);
    // Undriven pad falls to the pull-down, never a stale level
    assign wire_a = pin_a.oe ? pin_a.level : 1'b0;
    assign wire_b = pin_b.oe ? pin_b.level : 1'b0;
endmodule : dspt_load

// file: dspt_timer_checker.sv
// Port-level assertions for the dual-slope PWM timer
`timescale 1ns/1ps
module dspt_timer_checker (
    // Clock and reset
    input wire logic           pclk,
    input wire logic           presetn,
    // APB
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [7:0]     paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // Pins
    input dspt_pkg::dspt_pin_t pin_a,
    input dspt_pkg::dspt_pin_t pin_b
);
    logic [7:0]  ctla_reg;
    logic [7:0]  ctlb_reg;
    logic [1:0]  dir_reg;
    logic [15:0] msk_reg;
    // Completed transfers and decoded mode
    wire wr_done = psel && penable && pready && pwrite;
    wire rd_done = psel && penable && pready && !pwrite;
    wire [3:0] wgm = {ctlb_reg[4:3], ctla_reg[1:0]};
    wire stp = !(ctlb_reg[2:0] inside {[3'h1:3'h5]}) || !(wgm inside {[4'h1:4'h3], [4'h8:4'hB]});
    wire tgl_ok = (wgm == dspt_pkg::WGM_PFC_A) || (wgm == dspt_pkg::WGM_PC_A);
    wire hold_a = (ctla_reg[7:6] == 2'h1) && !tgl_ok;
    wire hold_b = ctla_reg[5:4] == 2'h1;
    wire [15:0] msk_now = (wgm == dspt_pkg::WGM_PC8) ? dspt_pkg::TOP_8BIT :
                          (wgm == dspt_pkg::WGM_PC9) ? dspt_pkg::TOP_9BIT :
                          (wgm == dspt_pkg::WGM_PC10) ? dspt_pkg::TOP_10BIT : dspt_pkg::TOP_FULL;
    // Shadow state; mask kept from write time, as the design does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctla_reg <= 8'h00;
            ctlb_reg <= 8'h00;
            dir_reg  <= 2'h0;
            msk_reg  <= 16'hFFFF;
        end else if (wr_done) begin
            if (paddr == dspt_pkg::OFF_CTRL_A) ctla_reg <= pwdata[7:0];
            if (paddr == dspt_pkg::OFF_CTRL_B) ctlb_reg <= pwdata[7:0];
            if (paddr == dspt_pkg::OFF_PIN_DIR) dir_reg <= pwdata[1:0];
            if (paddr == dspt_pkg::OFF_CMP_A) msk_reg <= msk_now;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oe_chan_a: assert property (pin_a.oe == (dir_reg[0] && ctla_reg[7:6] != 2'h0))
        else $error("pin a enable wrong");
    a_oe_chan_b: assert property (pin_b.oe == (dir_reg[1] && ctla_reg[5:4] != 2'h0))
        else $error("pin b enable wrong");
    // Two cycles deep: a match taken just before stopping may still land
    a_freeze_a: assert property ($past(stp) && $past(stp, 2) |-> $stable(pin_a.level))
        else $error("pin a moved while stopped");
    a_freeze_b: assert property ($past(stp) && $past(stp, 2) |-> $stable(pin_b.level))
        else $error("pin b moved while stopped");
    a_hold_field_a: assert property ($past(hold_a) && $past(hold_a, 2) |-> $stable(pin_a.level))
        else $error("pin a toggled outside its modes");
    a_hold_field_b: assert property ($past(hold_b) && $past(hold_b, 2) |-> $stable(pin_b.level))
        else $error("pin b toggled");
    a_mask_fixed: assert property (rd_done && paddr == dspt_pkg::OFF_CMP_A |-> (prdata & ~{16'h0, msk_reg}) == 32'h0)
        else $error("compare bits above resolution");
    a_mode_split: assert property (rd_done && paddr == dspt_pkg::OFF_CTRL_B |-> prdata[4:3] == ctlb_reg[4:3])
        else $error("mode high bits wrong");
    a_unmapped_err: assert property (psel && !penable && paddr > dspt_pkg::OFF_PIN_DIR |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    c_mask_read: cover property (rd_done && paddr == dspt_pkg::OFF_CMP_A);
    c_toggle: cover property (tgl_ok && ctla_reg[7:6] == 2'h1 && $changed(pin_a.level));
    c_unmapped: cover property (pslverr && penable);
endmodule : dspt_timer_checker

bind dspt_timer dspt_timer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_a(pin_a), .pin_b(pin_b));

// file: dspt_timer_tb.sv
// Self-checking testbench for the dual-slope PWM timer
`timescale 1ns/1ps
module dspt_timer_tb;
    logic                pclk;
    logic                presetn = 1'b0;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [7:0]          paddr   = 8'h00;
    logic [31:0]         pwdata  = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    dspt_pkg::dspt_pin_t pin_a;
    dspt_pkg::dspt_pin_t pin_b;
    logic                wire_a;
    logic                wire_b;
    logic                meas_go = 1'b0;
    logic                meas_ch = 1'b0;
    logic [32:0]         reg_q[$];
    logic [32:0]         pin_q[$];
    int                  bad_count = 0;
    int                  tests_run = 0;
    int                  cycles = 0;
    int                  seed = 41;

    dspt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_a(pin_a), .pin_b(pin_b));
    dspt_load u_load (.pin_a(pin_a), .pin_b(pin_b), .wire_a(wire_a), .wire_b(wire_b));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic final_report();
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic compare(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare

    // One APB transfer; held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        reg_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic meas(input logic ch, input logic [32:0] e);
        pin_q.push_back(e);
        meas_ch = ch;
        meas_go = 1'b1;
        wait (meas_go === 1'b0);
    endtask : meas

    // Stop, park the count at zero, load values, then start
    task automatic cfg(input logic [15:0] cap, ca, cb, input logic [7:0] ca_ctl, cb_ctl);
        apb(1'b1, dspt_pkg::OFF_CTRL_B, 32'h0);
        apb(1'b1, dspt_pkg::OFF_CTRL_A, 32'h0);
        apb(1'b1, dspt_pkg::OFF_COUNT, 32'h0);
        apb(1'b1, dspt_pkg::OFF_PIN_DIR, 32'h3);
        apb(1'b1, dspt_pkg::OFF_CAPTURE, 32'(cap));
        apb(1'b1, dspt_pkg::OFF_CMP_A, 32'(ca));
        apb(1'b1, dspt_pkg::OFF_CMP_B, 32'(cb));
        apb(1'b1, dspt_pkg::OFF_CTRL_A, 32'(ca_ctl));
        apb(1'b1, dspt_pkg::OFF_CTRL_B, 32'(cb_ctl));
        repeat (40) @(posedge pclk);
    endtask : cfg

    task automatic flags(input logic [32:0] e);
        apb(1'b1, dspt_pkg::OFF_FLAGS, 32'hF);
        repeat (20) @(posedge pclk);
        rd(dspt_pkg::OFF_FLAGS, e);
    endtask : flags

    function automatic logic pw();
        return meas_ch ? wire_b : wire_a;
    endfunction : pw

    // Read results against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) compare({pslverr, prdata}, reg_q.pop_front());
    end

    // Pin watcher: high and low run lengths from a rising edge, else the steady level
    always begin : pin_mon
        logic p;
        logic got;
        int n;
        int h;
        int l;
        wait (meas_go === 1'b1);
        got = 1'b0;
        n = 0;
        h = 0;
        l = 0;
        while (!got && n < 200) begin
            p = pw();
            @(posedge pclk);
            got = (p === 1'b0) && (pw() === 1'b1);
            n++;
        end
        while (got && pw() === 1'b1 && h < 999) begin @(posedge pclk); h++; end
        while (got && pw() === 1'b0 && l < 999) begin @(posedge pclk); l++; end
        compare(got ? {1'b0, h[15:0], l[15:0]} : {32'h0, pw()}, pin_q.pop_front());
        meas_go = 1'b0;
    end

    // Cycle ceiling; the whole run needs under two thousand
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        logic [31:0] rnd;
        logic [15:0] tops [3];
        tops = '{dspt_pkg::TOP_8BIT, dspt_pkg::TOP_9BIT, dspt_pkg::TOP_10BIT};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(dspt_pkg::OFF_CTRL_B, 33'h0);
        rd(8'h20, {1'b1, 32'h0});
        // Random compare writes under each fixed TOP
        for (int i = 0; i < 3; i++) begin
            rnd = $random(seed);
            apb(1'b1, dspt_pkg::OFF_CTRL_A, 32'(i + 1));
            apb(1'b1, dspt_pkg::OFF_CMP_A, rnd);
            rd(dspt_pkg::OFF_CMP_A, {17'h0, rnd[15:0] & tops[i]});
        end
        // Capture as TOP 7, channel B at 2, A parked on field one
        cfg(16'h0007, 16'h0000, 16'h0002, 8'h62, 8'h11);
        meas(1'b1, {1'b0, 16'h0004, 16'h000A});
        apb(1'b1, dspt_pkg::OFF_CTRL_A, 32'h72);
        meas(1'b1, {1'b0, 16'h000A, 16'h0004});
        apb(1'b1, dspt_pkg::OFF_CTRL_B, 32'h12);
        meas(1'b1, {1'b0, 16'h0050, 16'h0020});
        apb(1'b1, dspt_pkg::OFF_CTRL_B, 32'h11);
        // Live TOP change done in frequency-correct mode, new TOP above both compares
        apb(1'b1, dspt_pkg::OFF_CTRL_A, 32'h70);
        apb(1'b1, dspt_pkg::OFF_CAPTURE, 32'hB);
        meas(1'b1, {1'b0, 16'h0012, 16'h0004});
        // Compare A as TOP at the 2-bit minimum, toggling; B above TOP
        cfg(16'h0007, 16'h0003, 16'h0005, 8'h53, 8'h11);
        meas(1'b0, {1'b0, 16'h0006, 16'h0006});
        flags(33'h3);
        // Frequency-correct, compare A as TOP, toggling; B at zero matches at bottom
        cfg(16'h0007, 16'h0003, 16'h0000, 8'h41, 8'h11);
        meas(1'b0, {1'b0, 16'h0006, 16'h0006});
        flags(33'h7);
        // Frequency-correct, capture TOP, extreme compares
        cfg(16'h0007, 16'h0000, 16'h0007, 8'hE0, 8'h11);
        meas(1'b0, 33'h1);
        meas(1'b1, 33'h1);
        flags(33'hF);
        apb(1'b1, dspt_pkg::OFF_PIN_DIR, 32'h0);
        meas(1'b0, 33'h0);
        final_report();
    end
endmodule : dspt_timer_tb
